//--- bench/sps_i2c_master_model.sv
// Behavioural two-wire bus master with a 125 ns clock period.
// Assumes pulled-up wires resolved by the bench from all enables.
`timescale 1ns/100ps
`default_nettype none

module sps_i2c_master_model (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_n_o,
  output logic sda_oe_n_o
);
  // ----------------------------------------------------------------
  // Bus primitives
  // ----------------------------------------------------------------
  initial begin
    scl_oe_n_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end

  // Release clock and wait out any stretch, bounded against a hang
  task automatic rel_scl();
    int n;
    n = 0;
    scl_oe_n_o = 1'b1;
    while (scl_i !== 1'b1 && n < 200) begin
      #8;
      n++;
    end
  endtask

  // One bit: data set mid-low, sampled in the middle of the high phase
  task automatic bit_x(input logic b, output logic r);
    #20 sda_oe_n_o = b;
    #42.5 rel_scl();
    #31.25 r = sda_i;
    #31.25 scl_oe_n_o = 1'b0;
  endtask

  // Nine clocks: eight data bits MSB first, then the acknowledge bit
  task automatic frame(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
  endtask

  // Works from idle and as a repeated start
  task automatic start();
    sda_oe_n_o = 1'b1;
    #31.25 rel_scl();
    #31.25 sda_oe_n_o = 1'b0;
    #62.5 scl_oe_n_o = 1'b0;
  endtask

  task automatic stop();
    #20 sda_oe_n_o = 1'b0;
    #42.5 rel_scl();
    #62.5 sda_oe_n_o = 1'b1;
    #62.5;
  endtask
endmodule // sps_i2c_master_model
`default_nettype wire

//--- bench/sps_i2c_slave_asserts.sv
// Checker for the readout slave: pin drive, bus state, stretch and ready.
// Assumes a bind onto sps_i2c_slave with scl_i and sda_i as wire levels.
`timescale 1ns/100ps
`default_nettype none

module sps_i2c_slave_asserts #(
  parameter int MEAS_CYCLES = 40
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic scl_oe_n_o,
  input wire logic sda_oe_n_o,
  input wire logic data_ready_o,
  input wire logic bus_busy_o
);
  // ----------------------------------------------------------------
  // Helper: cycles since ready last rose
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic rdy_d;
  logic [15:0] gap;

  // Saturates so a long idle spell never wraps into a false short gap
  always_ff @(posedge clk_i) begin
    rdy_d <= data_ready_o;
    if (!nrst_i) begin
      gap <= 16'hFFFF;
    end else if (data_ready_o && !rdy_d) begin
      gap <= 16'h0001;
    end else if (gap != 16'hFFFF) begin
      gap <= gap + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  pins_drive_low_a: assert property (!scl_o && !sda_o)
    else $error("pin drive level not low");
  start_busy_a: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] bus_busy_o)
    else $error("bus not busy after start");
  stop_free_a: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !bus_busy_o)
    else $error("bus not free after stop");
  idle_released_a: assert property (!bus_busy_o |-> sda_oe_n_o && scl_oe_n_o)
    else $error("line pulled on free bus");
  stretch_length_a: assert property ($fell(scl_oe_n_o) |=> !scl_oe_n_o [*5] ##1 scl_oe_n_o)
    else $error("stretch length wrong");
  stretch_low_a: assert property ($fell(scl_oe_n_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("stretch not after clock low");
  sda_on_low_a: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data changed while clock high");
  ready_clear_a: assert property ($fell(data_ready_o) |-> bus_busy_o)
    else $error("ready cleared outside a transfer");
  ready_spacing_a: assert property ($rose(data_ready_o) |-> gap >= MEAS_CYCLES)
    else $error("ready rose too soon");
endmodule // sps_i2c_slave_asserts

bind sps_i2c_slave sps_i2c_slave_asserts #(.MEAS_CYCLES(MEAS_CYCLES)) u_sva (
  .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .sda_o(sda_o),
  .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o), .data_ready_o(data_ready_o),
  .bus_busy_o(bus_busy_o)
);
`default_nettype wire

//--- bench/sps_i2c_slave_tb.sv
// Self-checking bench for the readout slave in sleep mode, then free-running mode.
// Assumes sps_consts.svh on the include path; master model drives the link.
`timescale 1ns/100ps
`default_nettype none
`include "sps_consts.svh"

module sps_i2c_slave_tb;
  // ----------------------------------------------------------------
  // Design, partner and wires
  // ----------------------------------------------------------------
  localparam int MEAS = 2000;
  localparam logic [6:0] ADDR = `SPS_ADDR_VAR1;
  logic clk = 1'b0;
  logic nrst, sleep_mode, diag;
  logic [13:0] bridge, bsnap;
  logic [10:0] temp, tsnap;
  logic scl_oe_n, sda_oe_n, m_scl_oe_n, m_sda_oe_n, ready, busy;
  logic [8:0] rx;
  logic [6:0] bad [2] = '{`SPS_ADDR_VAR0, `SPS_ADDR_VAR2};
  int n_fail = 0;
  int samples_checked = 0;
  wire scl_w;
  wire sda_w;

  // Pull-ups: a wire is low only while some party enables its driver
  assign scl_w = !(m_scl_oe_n === 1'b0 || scl_oe_n === 1'b0);
  assign sda_w = !(m_sda_oe_n === 1'b0 || sda_oe_n === 1'b0);
  always #4 clk = ~clk;

  sps_i2c_slave #(.ADDR_SEL(2'h1), .MEAS_CYCLES(MEAS)) uut (
    .clk_i(clk), .nrst_i(nrst), .scl_i(scl_w), .scl_o(), .scl_oe_n_o(scl_oe_n),
    .sda_i(sda_w), .sda_o(), .sda_oe_n_o(sda_oe_n), .sleep_mode_i(sleep_mode),
    .diag_i(diag), .bridge_sample_i(bridge), .temp_sample_i(temp),
    .data_ready_o(ready), .bus_busy_o(busy)
  );
  sps_i2c_master_model m (
    .scl_i(scl_w), .sda_i(sda_w), .scl_oe_n_o(m_scl_oe_n), .sda_oe_n_o(m_sda_oe_n)
  );

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pkt(input logic [1:0] st, input logic [13:0] b, input logic [10:0] t);
    return {st, b, t, `SPS_TAIL_PAD};
  endfunction

  // Value taken at the call; compared after the next falling edge
  task automatic chk_bit(input logic got, input logic exp, input string what);
    @(negedge clk);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Read header then n bytes; only the last one is refused
  task automatic fetch(input int n, input logic [1:0] st);
    logic [31:0] exp;
    exp = pkt(st, bsnap, tsnap);
    m.start();
    m.frame({ADDR, `SPS_DIR_READ, 1'b1}, rx);
    chk_bit(rx[0], 1'b0, "header ack");
    chk_bit(ready, 1'b0, "ready cleared");
    chk_bit(busy, 1'b1, "bus busy");
    for (int i = 0; i < n; i++) begin
      m.frame({8'hFF, i == n - 1}, rx);
      chk_byte(rx[8:1], exp[31 - 8 * i -: 8], "packet byte");
    end
  endtask

  // Measurement lands within its cycle count plus 100 cycles; snapshot what it captured
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < MEAS + 100) begin
      @(posedge clk);
      n++;
    end
    chk_bit(ready, 1'b1, "data ready");
    bsnap = bridge;
    tsnap = temp;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    sleep_mode = 1'b1;
    diag = 1'b0;
    void'($urandom(50));
    bridge = 14'($urandom);
    temp = 11'($urandom);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk_bit(ready, 1'b0, "ready after reset");
    // Measurement request: header, acknowledge, stop at once
    m.start();
    m.frame({ADDR, `SPS_DIR_READ, 1'b1}, rx);
    chk_bit(rx[0], 1'b0, "request ack");
    m.stop();
    chk_bit(busy, 1'b0, "bus free");
    wait_ready();
    // Boundary samples captured by the measurement the next fetch starts
    @(posedge clk);
    bridge <= 14'h3FFF;
    temp <= 11'h000;
    fetch(4, `SPS_STAT_NORMAL);
    m.stop();
    // Second fetch of the same data: stale, then refused and abandoned
    fetch(2, `SPS_STAT_BUSY);
    m.frame(9'h1FF, rx);
    chk_byte(rx[8:1], 8'hFF, "silent after nack");
    m.stop();
    wait_ready();
    @(posedge clk);
    diag <= 1'b1;
    fetch(3, `SPS_STAT_DIAG);
    m.stop();
    @(posedge clk);
    diag <= 1'b0;
    wait_ready();
    // Foreign addresses and a write header are left unanswered
    for (int i = 0; i < 3; i++) begin
      m.start();
      m.frame(i < 2 ? {bad[i], 2'b11} : {ADDR, 2'b01}, rx);
      chk_bit(rx[0], 1'b1, "no ack");
      m.frame(9'h1FF, rx);
      chk_byte(rx[8:1], 8'hFF, "released");
      m.stop();
    end
    chk_bit(ready, 1'b1, "ready kept");
    // Random samples and fetch lengths
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      bridge <= 14'($urandom);
      temp <= 11'($urandom);
      fetch(2 + $urandom_range(0, 2), `SPS_STAT_NORMAL);
      m.stop();
      wait_ready();
    end
    // Free-running mode measures again without being asked
    @(posedge clk);
    sleep_mode <= 1'b0;
    wait_ready();
    fetch(2, `SPS_STAT_NORMAL);
    m.stop();
    wait_ready();
    tally_and_finish();
  end
endmodule // sps_i2c_slave_tb
`default_nettype wire

//--- inc/sps_consts.svh
// Constants of the sensor readout slave: addresses, packet layout,
// status codes and timing counts.
// Assumes a 125 MHz block clock; included by the package and the bench.
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// ----------------------------------------------------------------
// Slave addresses, one per interface variant
// ----------------------------------------------------------------
`define SPS_ADDR_VAR0 7'h28
`define SPS_ADDR_VAR1 7'h36
`define SPS_ADDR_VAR2 7'h46
`define SPS_DIR_READ 1'h1

// ----------------------------------------------------------------
// Packet layout
// ----------------------------------------------------------------
`define SPS_BYTE_LAST_BIT 4'h7
`define SPS_HDR_BITS 4'h8
`define SPS_PACKET_BYTES 3'h4
`define SPS_PACKET_W 32
`define SPS_BRIDGE_W 14
`define SPS_TEMP_W 11
`define SPS_TAIL_PAD 5'h00

// Packet status codes in the two leading bits
`define SPS_STAT_NORMAL 2'h0
`define SPS_STAT_COMMAND 2'h1
`define SPS_STAT_BUSY 2'h2
`define SPS_STAT_DIAG 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPS_CLK_NS 8
`define SPS_STRETCH_NS 40
`define SPS_STRETCH_CYC ((`SPS_STRETCH_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`define SPS_MEAS_US 1500
`define SPS_MEAS_CYC ((`SPS_MEAS_US * 1000) / `SPS_CLK_NS)
`define SPS_MEAS_CW 24

`endif

//--- inc/sps_pkg.sv
// Types of the sensor readout slave: state codes and state records.
// Assumes sps_consts.svh on the include path.
`include "sps_consts.svh"

package sps_pkg;

  // ----------------------------------------------------------------
  // Bus-facing state machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    SPS_IDLE     = 7'h01,
    SPS_HEADER   = 7'h02,
    SPS_HDR_ACK  = 7'h04,
    SPS_STRETCH  = 7'h08,
    SPS_SEND     = 7'h10,
    SPS_SEND_ACK = 7'h20,
    SPS_IGNORE   = 7'h40
  } sps_state_t;

  // Top-level state record
  typedef struct packed {
    sps_state_t st;
    logic [`SPS_PACKET_W-1:0] shift;
    logic [3:0] bitcnt;
    logic [2:0] bytecnt;
    logic [3:0] hold;
    logic ack_seen;
    logic scl_d;
    logic sda_d;
    logic scl_oe_n;
    logic sda_oe_n;
    logic pin_level;
    logic ready;
    logic bus_busy;
    logic fresh;
    logic meas_start;
    logic [`SPS_BRIDGE_W-1:0] out_bridge;
    logic [`SPS_TEMP_W-1:0] out_temp;
  } sps_top_t;

  // Measurement engine state
  typedef struct packed {
    logic running;
    logic [`SPS_MEAS_CW-1:0] cnt;
    logic done;
    logic [`SPS_BRIDGE_W-1:0] bridge;
    logic [`SPS_TEMP_W-1:0] temp;
  } sps_meas_t;

  // Two-stage synchroniser state
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } sps_sync_t;

endpackage

//--- verilog/sps_i2c_slave.sv
// Sensor readout slave on a two-wire bus: header decode, acknowledge,
// clock stretching, packet transmission and the data-ready pin.
// Assumes open-drain pins resolved outside; SCL and SDA are
// asynchronous to clk_i and sampled through sps_sync.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Respond only to the factory address chosen by variant parameter.
// - Ready pin rises on fresh data, falls when addressed again.
// - Bus busy from START to STOP, free after STOP.
// - Receiver pulls SDA low in ninth bit to acknowledge.
// - Missing master acknowledge ends transmission, device goes idle.
// - Hold SCL low after acknowledge pulse, release when ready.
// - Bytes are eight bits, MSB first, each followed by acknowledge.
// - Header is address plus direction; one means slave sends.
// - Every command starts with read header; device acknowledges it.
// - Measurement request plus two, three or four byte fetches.
// - In sleep, request wakes device and runs full measurement.
// - Keep sending bytes until master not-acknowledges and stops.
// - Three-byte fetch: two bridge bytes with status, then temperature.
// - Four-byte fetch: master acknowledges third, reads fourth byte.
// - Bridge data 14 bits: six high bits, then eight low.
// - Status pair codes normal, command, busy or diagnostic.
module sps_i2c_slave
  import sps_pkg::*;
#(
  parameter logic [1:0] ADDR_SEL = 2'h0,
  parameter int MEAS_CYCLES = `SPS_MEAS_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic sleep_mode_i,
  input wire logic diag_i,
  input wire logic [`SPS_BRIDGE_W-1:0] bridge_sample_i,
  input wire logic [`SPS_TEMP_W-1:0] temp_sample_i,
  output logic data_ready_o,
  output logic bus_busy_o
);

  // ----------------------------------------------------------------
  // Address selection
  // ----------------------------------------------------------------
  // Variant 3 is not a legal setting and falls back to variant 0
  localparam logic [6:0] SLAVE_ADDR = (ADDR_SEL == 2'h2) ? `SPS_ADDR_VAR2 :
                                      (ADDR_SEL == 2'h1) ? `SPS_ADDR_VAR1 :
                                      `SPS_ADDR_VAR0;
  localparam logic [3:0] STRETCH_CYC = 4'(`SPS_STRETCH_CYC);

  sps_top_t q;
  sps_top_t next_q;

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [`SPS_BRIDGE_W-1:0] meas_bridge;
  logic [`SPS_TEMP_W-1:0] meas_temp;
  logic meas_done;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  sps_sync u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i({scl_i, sda_i}),
    .pin_o(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // ----------------------------------------------------------------
  // Measurement engine
  // ----------------------------------------------------------------
  sps_measure #(
    .MEAS_CYCLES(MEAS_CYCLES)
  ) u_meas (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(q.meas_start),
    .sleep_i(sleep_mode_i),
    .bridge_i(bridge_sample_i),
    .temp_i(temp_sample_i),
    .bridge_o(meas_bridge),
    .temp_o(meas_temp),
    .done_o(meas_done)
  );

  // ----------------------------------------------------------------
  // Bus event decode
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [1:0] pkt_status;
  logic [`SPS_PACKET_W-1:0] packet;

  // START and STOP are SDA edges while SCL stays high
  assign scl_rise = scl_s & ~q.scl_d;
  assign scl_fall = ~scl_s & q.scl_d;
  assign start_cond = scl_s & q.scl_d & q.sda_d & ~sda_s;
  assign stop_cond = scl_s & q.scl_d & ~q.sda_d & sda_s;

  // Data already fetched once reports busy, i.e. stale
  assign pkt_status = !q.fresh ? `SPS_STAT_BUSY :
                      diag_i ? `SPS_STAT_DIAG : `SPS_STAT_NORMAL;

  // Status and bridge first, then temperature, pad bits last
  assign packet = {pkt_status, q.out_bridge, q.out_temp,
                   `SPS_TAIL_PAD};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.scl_d = scl_s;
    next_q.sda_d = sda_s;
    next_q.meas_start = 1'b0;

    // Bus occupancy tracks START and STOP regardless of address
    if (start_cond) begin
      next_q.bus_busy = 1'b1;
    end else if (stop_cond) begin
      next_q.bus_busy = 1'b0;
    end

    if (stop_cond) begin
      // STOP always frees both lines and returns to idle
      next_q.st = SPS_IDLE;
      next_q.sda_oe_n = 1'b1;
      next_q.scl_oe_n = 1'b1;
    end else if (start_cond) begin
      // Repeated START restarts header reception
      next_q.st = SPS_HEADER;
      next_q.bitcnt = 4'h0;
      next_q.sda_oe_n = 1'b1;
      next_q.scl_oe_n = 1'b1;
    end else begin
      unique case (q.st)
        SPS_IDLE: begin
          next_q.sda_oe_n = 1'b1;
          next_q.scl_oe_n = 1'b1;
        end

        SPS_HEADER: begin
          // Sample on rising SCL, MSB first
          if (scl_rise) begin
            next_q.shift = {q.shift[`SPS_PACKET_W-2:0], sda_s};
            next_q.bitcnt = q.bitcnt + 4'h1;
          end
          if (scl_fall && q.bitcnt == `SPS_HDR_BITS) begin
            if (q.shift[7:1] == SLAVE_ADDR &&
                q.shift[0] == `SPS_DIR_READ) begin
              next_q.sda_oe_n = 1'b0;
              next_q.ready = 1'b0;
              next_q.st = SPS_HDR_ACK;
            end else begin
              // Other address or a write header: stay off the bus
              next_q.st = SPS_IGNORE;
            end
          end
        end

        SPS_HDR_ACK: begin
          // Acknowledge held through the ninth clock
          if (scl_fall) begin
            next_q.scl_oe_n = 1'b0;
            next_q.shift = packet;
            next_q.sda_oe_n = packet[`SPS_PACKET_W-1];
            next_q.fresh = 1'b0;
            next_q.bitcnt = 4'h0;
            next_q.bytecnt = 3'h0;
            next_q.hold = STRETCH_CYC;
            // Any read header wakes a sleeping sensor; a plain request
            // simply stops here, a fetch gets the snapshot already held
            next_q.meas_start = sleep_mode_i;
            next_q.st = SPS_STRETCH;
          end
        end

        SPS_STRETCH: begin
          // First bit already on SDA, so release gives full setup
          if (q.hold != 4'h0) begin
            next_q.hold = q.hold - 4'h1;
          end else begin
            next_q.scl_oe_n = 1'b1;
            next_q.st = SPS_SEND;
          end
        end

        SPS_SEND: begin
          // Next bit goes out on each falling SCL
          if (scl_fall) begin
            next_q.shift = {q.shift[`SPS_PACKET_W-2:0], 1'b1};
            if (q.bitcnt == `SPS_BYTE_LAST_BIT) begin
              next_q.sda_oe_n = 1'b1;
              next_q.bitcnt = 4'h0;
              next_q.ack_seen = 1'b0;
              next_q.st = SPS_SEND_ACK;
            end else begin
              next_q.sda_oe_n = q.shift[`SPS_PACKET_W-2];
              next_q.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end

        SPS_SEND_ACK: begin
          // Master's ninth bit decides whether another byte follows
          if (scl_rise) begin
            if (sda_s) begin
              next_q.st = SPS_IGNORE;
            end else begin
              next_q.ack_seen = 1'b1;
            end
          end
          if (scl_fall && q.ack_seen) begin
            // Past the fourth byte the shifter yields all ones
            next_q.sda_oe_n = q.shift[`SPS_PACKET_W-1];
            if (q.bytecnt != `SPS_PACKET_BYTES) begin
              next_q.bytecnt = q.bytecnt + 3'h1;
            end
            next_q.st = SPS_SEND;
          end
        end

        SPS_IGNORE: begin
          // Lines released until the next START or STOP
          next_q.sda_oe_n = 1'b1;
          next_q.scl_oe_n = 1'b1;
        end

        default: begin
          next_q.st = SPS_IDLE;
          next_q.sda_oe_n = 1'b1;
          next_q.scl_oe_n = 1'b1;
        end
      endcase
    end

    // New results win over a clear in the same cycle
    if (meas_done) begin
      next_q.out_bridge = meas_bridge;
      next_q.out_temp = meas_temp;
      next_q.fresh = 1'b1;
      next_q.ready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '{st: SPS_IDLE, shift: '0, bitcnt: 4'h0, bytecnt: 3'h0,
             hold: 4'h0, ack_seen: 1'b0, scl_d: 1'b1, sda_d: 1'b1,
             scl_oe_n: 1'b1, sda_oe_n: 1'b1, pin_level: 1'b0,
             ready: 1'b0, bus_busy: 1'b0, fresh: 1'b0,
             meas_start: 1'b0, out_bridge: '0, out_temp: '0};
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from the state register
  // ----------------------------------------------------------------
  // Open drain: the driven level is always low, the enable decides
  assign scl_o = q.pin_level;
  assign sda_o = q.pin_level;
  assign scl_oe_n_o = q.scl_oe_n;
  assign sda_oe_n_o = q.sda_oe_n;
  assign data_ready_o = q.ready;
  assign bus_busy_o = q.bus_busy;

endmodule // sps_i2c_slave

`default_nettype wire

//--- verilog/sps_measure.sv
// Measurement engine: runs a conversion cycle and latches the sampled
// bridge and temperature results into the output register.
// Assumes sample inputs are stable logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module sps_measure
  import sps_pkg::*;
#(
  parameter int MEAS_CYCLES = `SPS_MEAS_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic sleep_i,
  input wire logic [`SPS_BRIDGE_W-1:0] bridge_i,
  input wire logic [`SPS_TEMP_W-1:0] temp_i,
  output logic [`SPS_BRIDGE_W-1:0] bridge_o,
  output logic [`SPS_TEMP_W-1:0] temp_o,
  output logic done_o
);

  sps_meas_t q;
  sps_meas_t next_q;

  // ----------------------------------------------------------------
  // Cycle control: sleep waits for a wake, otherwise free-running
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (!q.running) begin
      if (start_i || !sleep_i) begin
        next_q.running = 1'b1;
        next_q.cnt = '0;
      end
    end else if (q.cnt == `SPS_MEAS_CW'(MEAS_CYCLES - 1)) begin
      // Results land in one cycle so readers never see half an update
      next_q.running = 1'b0;
      next_q.done = 1'b1;
      next_q.bridge = bridge_i;
      next_q.temp = temp_i;
    end else begin
      next_q.cnt = q.cnt + `SPS_MEAS_CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign bridge_o = q.bridge;
  assign temp_o = q.temp;
  assign done_o = q.done;

endmodule // sps_measure

`default_nettype wire

//--- verilog/sps_sync.sv
// Two-flop synchroniser for the SCL and SDA pin levels.
// Assumes raw pin inputs asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none

module sps_sync
  import sps_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] pin_i,
  output logic [1:0] pin_o
);

  sps_sync_t q;
  sps_sync_t next_q;

  // ----------------------------------------------------------------
  // Stage one feeds stage two only
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.s1 = pin_i;
    next_q.s2 = q.s1;
  end

  // Idle bus lines are high, so reset to released
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '{s1: 2'h3, s2: 2'h3};
    end else begin
      q <= next_q;
    end
  end

  assign pin_o = q.s2;

endmodule // sps_sync

`default_nettype wire
